// ===== fdsp_regs.svh
`ifndef FDSP_REGS_SVH
`define FDSP_REGS_SVH
// Contract
// - Raw read input from the drive is an active-low pulse stream.
// - Controller select low picks head-load timer mode, high picks master-clock mode.
// - Internal clock divides reference by 2, 4 or 8 from controller/density/size selects.
// - Separator finds falling read edges and shifts its clock phase into the window clock.
// - Independent short-term and long-term correctors keep the window aligned.
// - Window half-cycle nominally 8 internal clocks, never below 6 or above 11.
// - Regenerated data pulses follow raw read; polarity set by controller select.
// - Advance emits a write pulse early, retard late, neither at nominal position.
// - Precomp code gives 0..312.5 ns at 16 MHz, doubled when size select is high.
// - With an 8 MHz reference all precomp shifts double.
// - Head-load delay is 40 ms with size low, 80 ms with size high, at 16 MHz.
// - Head-load timer works only in timer mode, inert in master-clock mode.
// - Settled output rises after the delay following head-load request; retriggerable.
// - Master-clock mode outputs 8 MHz or 4 MHz master clock at 16 MHz.
// - Write clock frequency follows controller, density and drive size selects.
// - 8 MHz reference halves every clock and doubles every head-load period.
// - Test low shortens head-load delay and initialises separator; normally held high.
// - Size low means 8-inch; density meaning depends on controller family.
// - Head-load delay is a parameter, settable over the documented range.
// - Each write data pulse arriving with none pending is forwarded with the chosen precompensation shift.
`define FDSP_REF_MHZ        16
`define FDSP_HLD_SHORT_MS   40
`define FDSP_HLD_LONG_MS    80
`define FDSP_HLD_SHORT_CYC  (`FDSP_HLD_SHORT_MS * `FDSP_REF_MHZ * 1000)
`define FDSP_HLD_LONG_CYC   (`FDSP_HLD_LONG_MS * `FDSP_REF_MHZ * 1000)
`define FDSP_HL_W           24
`define FDSP_TEST_SHIFT     8
`define FDSP_PC_STEP_PS     62500
`define FDSP_PC_STEP_CYC    ((`FDSP_PC_STEP_PS * `FDSP_REF_MHZ + 999999) / 1000000)
`define FDSP_PC_TAB         {5'h5, 5'h5, 5'h4, 5'h4, 5'h3, 5'h2, 5'h1, 5'h0}
`define FDSP_DIV_TAB        {3'h3, 3'h1, 3'h7, 3'h3, 3'h7, 3'h3, 3'h3, 3'h1}
`define FDSP_WCK_TAB        {6'hF, 6'h7, 6'h1F, 6'hF, 6'h7, 6'h3, 6'h7, 6'h3}
`define FDSP_HALF_NOM       4'h8
`define FDSP_HALF_MIN       4'h6
`define FDSP_HALF_MAX       4'hB
`define FDSP_HALF_MID       4'h4
`define FDSP_SC_ZERO        3'h2
`define FDSP_SC_TOP         3'h5
`define FDSP_LT_ZERO        2'h1
`define FDSP_LT_TOP         2'h2
`define FDSP_BIAS           4'h3
`define FDSP_PULSE_W        3'h4
`endif

// ===== fdsp_pkg.sv
package fdsp_pkg;
  typedef struct packed {
    logic ctrl_b;
    logic density_sel;
    logic drive_size_sel;
  } fdsp_mode_t;
  typedef struct packed {
    logic [2:0] sel;
    logic       advance;
    logic       retard;
  } fdsp_pc_t;
  typedef struct packed {
    logic       ref_clk;
    logic       raw_b;
    logic       wdat;
    logic       head_load_request;
    logic       test_b;
    fdsp_mode_t mode;
    fdsp_pc_t   pc;
  } fdsp_pins_t;
  typedef enum logic [1:0] {
    FDSP_WR_IDLE,
    FDSP_WR_WAIT,
    FDSP_WR_DRIVE
  } fdsp_wr_st_t;
  typedef struct packed {
    fdsp_pins_t  s1;
    fdsp_pins_t  s2;
    logic        ref_prev;
    logic        raw_prev;
    logic        wd_prev;
    logic        hld_prev;
    logic [2:0]  icnt;
    logic [3:0]  hcnt;
    logic [3:0]  hlim;
    logic [3:0]  wlen;
    logic [2:0]  sc;
    logic [1:0]  lt;
    logic        win;
    logic [2:0]  sep_cnt;
    logic        sep;
    fdsp_wr_st_t wst;
    logic [4:0]  wcnt;
    logic        wdo;
    logic [23:0] hl_cnt;
    logic        hl_done;
    logic [1:0]  mcnt;
    logic        mclk;
    logic        hlt;
    logic [5:0]  ccnt;
    logic        cko;
  } fdsp_state_t;
endpackage : fdsp_pkg

// ===== fdsp_top.sv
`timescale 1ns/1ps
`include "fdsp_regs.svh"
module fdsp_top #(
  parameter int unsigned HLD_SHORT_CYC = `FDSP_HLD_SHORT_CYC,
  parameter int unsigned HLD_LONG_CYC  = `FDSP_HLD_LONG_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 reference_clock_in_i,
  input  wire logic                 raw_read_in_b_i,
  input  wire logic                 write_data_in_i,
  input  wire logic                 head_load_request_i,
  input  wire logic                 test_b_i,
  input  wire fdsp_pkg::fdsp_mode_t mode_i,
  input  wire fdsp_pkg::fdsp_pc_t   precomp_i,
  output logic                      window_clock_o,
  output logic                      separated_data_o,
  output logic                      write_data_out_o,
  output logic                      head_settled_or_master_clock_o,
  output logic                      write_clock_out_o
);
  import fdsp_pkg::*;

  if (HLD_SHORT_CYC == 0 || HLD_LONG_CYC == 0 ||
      HLD_SHORT_CYC >= (1 << `FDSP_HL_W) || HLD_LONG_CYC >= (1 << `FDSP_HL_W)) begin : g_bad_hld
    $error("head-load count out of range");
  end

  localparam fdsp_state_t ST_RST = '{
    s1: '0, s2: '0, ref_prev: 1'b0, raw_prev: 1'b0, wd_prev: 1'b0, hld_prev: 1'b0,
    icnt: '0, hcnt: '0, hlim: `FDSP_HALF_NOM, wlen: '0, sc: `FDSP_SC_ZERO,
    lt: `FDSP_LT_ZERO, win: 1'b0, sep_cnt: '0, sep: 1'b0, wst: FDSP_WR_IDLE,
    wcnt: '0, wdo: 1'b0, hl_cnt: '0, hl_done: 1'b0, mcnt: '0, mclk: 1'b0,
    hlt: 1'b0, ccnt: '0, cko: 1'b0};

  // Mode index is {controller, density, size}
  function automatic logic [2:0] div_m1(input fdsp_mode_t m);
    logic [23:0] tab;
    tab = `FDSP_DIV_TAB;
    return tab[m*3 +: 3];
  endfunction : div_m1

  function automatic logic [5:0] wck_m1(input fdsp_mode_t m);
    logic [47:0] tab;
    tab = `FDSP_WCK_TAB;
    return tab[m*6 +: 6];
  endfunction : wck_m1

  function automatic logic [4:0] pc_shift(input logic [2:0] sel, input logic drive_size_sel);
    logic [39:0] tab;
    logic [4:0]  amt;
    tab = `FDSP_PC_TAB;
    amt = 5'(tab[sel*5 +: 5] * `FDSP_PC_STEP_CYC);
    return drive_size_sel ? 5'(amt << 1) : amt;
  endfunction : pc_shift

  fdsp_state_t s_q;
  fdsp_state_t s_d;
  fdsp_pins_t  pins;
  fdsp_mode_t  md;
  logic        ref_tick;
  logic        int_tick;
  logic        raw_fall;
  logic        wd_rise;
  logic        hld_rise;
  logic [4:0]  pc_amt;
  logic [3:0]  lim_sum;
  logic [23:0] hl_tgt;

  always_comb begin
    pins.ref_clk = reference_clock_in_i;
    pins.raw_b   = raw_read_in_b_i;
    pins.wdat    = write_data_in_i;
    pins.head_load_request     = head_load_request_i;
    pins.test_b  = test_b_i;
    pins.mode    = mode_i;
    pins.pc      = precomp_i;
  end

  always_comb begin
    s_d = s_q;
    // Every pin crosses two flops before any logic reads it
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
    md = s_q.s2.mode;
    s_d.ref_prev = s_q.s2.ref_clk;
    s_d.raw_prev = s_q.s2.raw_b;
    s_d.wd_prev  = s_q.s2.wdat;
    s_d.hld_prev = s_q.s2.head_load_request;
    // All timing counts reference edges, so a slower reference stretches everything
    ref_tick = s_q.s2.ref_clk & ~s_q.ref_prev;
    raw_fall = s_q.raw_prev & ~s_q.s2.raw_b;
    wd_rise  = s_q.s2.wdat & ~s_q.wd_prev;
    hld_rise = s_q.s2.head_load_request & ~s_q.hld_prev;
    pc_amt   = pc_shift(s_q.s2.pc.sel, md.drive_size_sel);
    int_tick = ref_tick && (s_q.icnt >= div_m1(md));
    lim_sum  = 4'(`FDSP_HALF_NOM + 4'(s_q.sc) + 4'(s_q.lt));
    hl_tgt   = md.drive_size_sel ? `FDSP_HL_W'(HLD_LONG_CYC) : `FDSP_HL_W'(HLD_SHORT_CYC);
    if (!s_q.s2.test_b) begin
      hl_tgt = hl_tgt >> `FDSP_TEST_SHIFT;
    end

    // Reference prescaler
    if (ref_tick) begin
      s_d.icnt = int_tick ? 3'h0 : 3'(s_q.icnt + 3'h1);
    end

    // Window clock: one half-cycle per hlim internal clocks
    if (!s_q.s2.test_b) begin
      s_d.hcnt = '0;
      s_d.hlim = `FDSP_HALF_NOM;
      s_d.wlen = '0;
      s_d.sc   = `FDSP_SC_ZERO;
      s_d.lt   = `FDSP_LT_ZERO;
      s_d.win  = 1'b0;
    end else begin
      if (int_tick) begin
        if (s_q.hcnt + 4'h1 >= s_q.hlim) begin
          s_d.win  = ~s_q.win;
          s_d.hcnt = '0;
          s_d.wlen = '0;
          s_d.sc   = `FDSP_SC_ZERO;
          // Correction is applied only at a half boundary so a half is never cut short
          if (lim_sum < `FDSP_HALF_MIN + `FDSP_BIAS) begin
            s_d.hlim = `FDSP_HALF_MIN;
          end else if (lim_sum - `FDSP_BIAS > `FDSP_HALF_MAX) begin
            s_d.hlim = `FDSP_HALF_MAX;
          end else begin
            s_d.hlim = 4'(lim_sum - `FDSP_BIAS);
          end
        end else begin
          s_d.hcnt = 4'(s_q.hcnt + 4'h1);
          s_d.wlen = 4'(s_q.wlen + 4'h1);
        end
      end
      // Short-term: phase error of this edge; long-term: slow drift integrator
      if (raw_fall) begin
        if (s_q.hcnt + 4'h2 <= `FDSP_HALF_MID) begin
          s_d.sc = '0;
        end else if (s_q.hcnt + 4'h2 - `FDSP_HALF_MID > 4'(`FDSP_SC_TOP)) begin
          s_d.sc = `FDSP_SC_TOP;
        end else begin
          s_d.sc = 3'(s_q.hcnt + 4'h2 - `FDSP_HALF_MID);
        end
        if (s_q.hcnt > `FDSP_HALF_MID && s_q.lt < `FDSP_LT_TOP) begin
          s_d.lt = 2'(s_q.lt + 2'h1);
        end else if (s_q.hcnt < `FDSP_HALF_MID && s_q.lt != 2'h0) begin
          s_d.lt = 2'(s_q.lt - 2'h1);
        end
      end
    end

    // Regenerated data pulse
    if (raw_fall) begin
      s_d.sep_cnt = `FDSP_PULSE_W;
    end else if (ref_tick && s_q.sep_cnt != '0) begin
      s_d.sep_cnt = 3'(s_q.sep_cnt - 3'h1);
    end
    s_d.sep = (s_d.sep_cnt != '0) ^ ~md.ctrl_b;

    // Write precompensation; a pulse arriving while one is pending is dropped
    case (s_q.wst)
      FDSP_WR_IDLE: begin
        if (wd_rise) begin
          s_d.wst = FDSP_WR_WAIT;
          if (s_q.s2.pc.advance) begin
            s_d.wcnt = '0;
          end else if (s_q.s2.pc.retard) begin
            s_d.wcnt = 5'(pc_amt << 1);
          end else begin
            s_d.wcnt = pc_amt;
          end
        end
      end
      FDSP_WR_WAIT: begin
        if (ref_tick) begin
          if (s_q.wcnt == '0) begin
            s_d.wst  = FDSP_WR_DRIVE;
            s_d.wdo  = 1'b1;
            s_d.wcnt = 5'(`FDSP_PULSE_W - 3'h1);
          end else begin
            s_d.wcnt = 5'(s_q.wcnt - 5'h1);
          end
        end
      end
      FDSP_WR_DRIVE: begin
        if (ref_tick) begin
          if (s_q.wcnt == '0) begin
            s_d.wst = FDSP_WR_IDLE;
            s_d.wdo = 1'b0;
          end else begin
            s_d.wcnt = 5'(s_q.wcnt - 5'h1);
          end
        end
      end
      default: begin
        s_d.wst = FDSP_WR_IDLE;
        s_d.wdo = 1'b0;
      end
    endcase

    // Head-load timer, timer mode only
    if (md.ctrl_b || !s_q.s2.head_load_request || hld_rise) begin
      s_d.hl_cnt  = '0;
      s_d.hl_done = 1'b0;
    end else if (ref_tick && !s_q.hl_done) begin
      if (s_q.hl_cnt + 24'h1 >= hl_tgt) begin
        s_d.hl_done = 1'b1;
      end else begin
        s_d.hl_cnt = 24'(s_q.hl_cnt + 24'h1);
      end
    end

    // Master clock: half period of one or two reference edges
    if (ref_tick) begin
      if (s_q.mcnt >= {1'b0, md.drive_size_sel}) begin
        s_d.mcnt = '0;
        s_d.mclk = ~s_q.mclk;
      end else begin
        s_d.mcnt = 2'(s_q.mcnt + 2'h1);
      end
    end
    s_d.hlt = md.ctrl_b ? s_d.mclk : s_d.hl_done;

    // Write clock
    if (ref_tick) begin
      if (s_q.ccnt >= wck_m1(md)) begin
        s_d.ccnt = '0;
        s_d.cko  = ~s_q.cko;
      end else begin
        s_d.ccnt = 6'(s_q.ccnt + 6'h1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign window_clock_o                 = s_q.win;
  assign separated_data_o               = s_q.sep;
  assign write_data_out_o               = s_q.wdo;
  assign head_settled_or_master_clock_o = s_q.hlt;
  assign write_clock_out_o              = s_q.cko;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence raw_fall_s;
    s_q.raw_prev && !s_q.s2.raw_b;
  endsequence

  sequence hld_rise_s;
    !s_q.hld_prev && s_q.s2.head_load_request && !md.ctrl_b;
  endsequence

  sequence wr_fire_s;
    s_q.wst == FDSP_WR_WAIT && ref_tick && s_q.wcnt == '0;
  endsequence

  sequence late_load_s;
    s_q.wst == FDSP_WR_IDLE && wd_rise && s_q.s2.pc.retard && !s_q.s2.pc.advance;
  endsequence

  half_length_a: assert property (
    ($changed(s_q.win) && $past(s_q.s2.test_b) && s_q.s2.test_b)
      |-> ($past(s_q.wlen) + 4'h1 >= `FDSP_HALF_MIN && $past(s_q.wlen) + 4'h1 <= `FDSP_HALF_MAX))
    else $error("window half-cycle length out of range");

  timer_inert_a: assert property (md.ctrl_b |=> (s_q.hl_cnt == '0 && !s_q.hl_done))
    else $error("head-load timer ran in master-clock mode");

  settle_cause_a: assert property (
    $rose(s_q.hl_done) |-> ($past(s_q.s2.head_load_request) && !$past(md.ctrl_b)))
    else $error("settled rose without head-load request");

  timer_retrigger_a: assert property (hld_rise_s |=> (!s_q.hl_done && s_q.hl_cnt == '0))
    else $error("head-load timer not restarted");

  late_shift_a: assert property (late_load_s |=> s_q.wcnt == 5'($past(pc_amt) << 1))
    else $error("late pulse delay is not two shifts");

  write_pulse_a: assert property (wr_fire_s |=> s_q.wdo ##1 s_q.wdo)
    else $error("write pulse not emitted");

  // The output mux follows the mode one cycle late, so a mode switch may move it freely
  master_edge_a: assert property (
    (md.ctrl_b && $past(md.ctrl_b) && $past(md.ctrl_b, 2) && $changed(s_q.hlt))
      |-> $past(ref_tick))
    else $error("master clock moved without reference edge");

  sep_level_a: assert property (raw_fall_s |=> s_q.sep == $past(md.ctrl_b))
    else $error("regenerated data not active after read edge");

  test_init_a: assert property (
    !s_q.s2.test_b |=> (s_q.hlim == `FDSP_HALF_NOM && !s_q.win && s_q.hcnt == '0))
    else $error("test input did not initialise separator");

  sequence early_load_s;
    s_q.wst == FDSP_WR_IDLE && wd_rise && s_q.s2.pc.advance;
  endsequence

  sequence nominal_load_s;
    s_q.wst == FDSP_WR_IDLE && wd_rise && !s_q.s2.pc.advance && !s_q.s2.pc.retard;
  endsequence

  sep_idle_a: assert property ((s_q.sep_cnt == 3'h1 && ref_tick && !raw_fall) |=> s_q.sep == !$past(md.ctrl_b))
    else $error("regenerated data did not return to idle");

  early_load_a: assert property (early_load_s |=> (s_q.wst == FDSP_WR_WAIT && s_q.wcnt == '0))
    else $error("early pulse was delayed");

  nominal_load_a: assert property (nominal_load_s |=> s_q.wcnt == $past(pc_amt))
    else $error("nominal pulse delay is not one shift");

  prescale_wrap_a: assert property (int_tick |=> s_q.icnt == '0)
    else $error("prescaler did not wrap on internal tick");

  // Test low may clear the window at any time, so only normal toggles need a tick
  window_edge_a: assert property (
    ($changed(s_q.win) && $past(s_q.s2.test_b)) |-> $past(int_tick))
    else $error("window clock moved without internal tick");

  half_limit_a: assert property (s_q.hlim >= `FDSP_HALF_MIN && s_q.hlim <= `FDSP_HALF_MAX)
    else $error("window half limit out of range");

  write_fall_a: assert property ($fell(s_q.wdo) |-> $past(ref_tick))
    else $error("write pulse ended off a reference edge");

  clock_out_edge_a: assert property ($changed(s_q.cko) |-> $past(ref_tick))
    else $error("write clock moved without reference edge");

  sync_stage_a: assert property (s_q.s2 == $past(s_q.s1))
    else $error("second synchroniser stage skipped");

  master_route_a: assert property (md.ctrl_b |=> s_q.hlt == s_q.mclk)
    else $error("master clock not routed to shared output");

  settle_route_a: assert property (!md.ctrl_b |=> s_q.hlt == s_q.hl_done)
    else $error("settled flag not routed to shared output");

endmodule : fdsp_top

// ===== fdsp_far_model.sv
`timescale 1ns/1ps
module fdsp_far_model (
  input  wire logic clk_i,
  output logic      reference_clock_o,
  output logic      raw_read_b_o,
  output logic      write_data_o
);
  // Reference oscillator runs free at 8 clk_i periods; odd start offset keeps its edges off clk_i edges
  initial begin
    reference_clock_o = 1'b0;
    raw_read_b_o      = 1'b1;
    write_data_o      = 1'b0;
    #13;
    forever begin
      #200 reference_clock_o = ~reference_clock_o;
    end
  end

  // Flux pulse from the drive is short and active low
  task automatic read_pulse;
    @(posedge clk_i);
    raw_read_b_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    raw_read_b_o <= 1'b1;
  endtask : read_pulse

  // Launched at a fixed reference phase so delays compare exactly
  task automatic write_pulse;
    @(posedge reference_clock_o);
    @(posedge clk_i);
    write_data_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    write_data_o <= 1'b0;
  endtask : write_pulse
endmodule : fdsp_far_model

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import fdsp_pkg::*;
  localparam int HS          = 40;
  localparam int HL          = 80;
  localparam int RC          = 8;
  localparam int PC_TAB  [8] = '{0, 1, 2, 3, 4, 4, 5, 5};
  localparam int WCK_TAB [8] = '{8, 16, 8, 16, 32, 64, 16, 32};
  localparam int DIV_TAB [8] = '{2, 4, 4, 8, 4, 8, 2, 4};
  logic       clk_i, rst_b_i, ref_clk, raw_b, wdat, head_load_request, test_b;
  logic       win, sep, wdo, hlt, wck;
  fdsp_mode_t mode;
  fdsp_pc_t   pc;
  int         fail_count, tests_run;

  initial clk_i = 1'b0;
  always #25 clk_i = ~clk_i;

  fdsp_far_model u_fdsp_far_model (
    .clk_i(clk_i), .reference_clock_o(ref_clk), .raw_read_b_o(raw_b), .write_data_o(wdat)
  );
  fdsp_top #(.HLD_SHORT_CYC(HS), .HLD_LONG_CYC(HL)) u_fdsp_top (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reference_clock_in_i(ref_clk), .raw_read_in_b_i(raw_b),
    .write_data_in_i(wdat), .head_load_request_i(head_load_request), .test_b_i(test_b), .mode_i(mode),
    .precomp_i(pc), .window_clock_o(win), .separated_data_o(sep), .write_data_out_o(wdo),
    .head_settled_or_master_clock_o(hlt), .write_clock_out_o(wck)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  function automatic logic pick(input int k);
    case (k)
      0: return win;
      1: return sep;
      2: return wdo;
      3: return hlt;
      default: return wck;
    endcase
  endfunction : pick

  // Bounded wait; counts falling clk edges until the output reaches v
  task automatic wait_lvl(input int k, input logic v, output int n);
    n = 0;
    while (pick(k) !== v && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 4000) check(32'h0, 32'h1);
  endtask : wait_lvl

  // First two cycles are thrown away since they may straddle a mode change
  task automatic period(input int k, output int p);
    int n;
    for (int j = 0; j < 2; j++) begin
      wait_lvl(k, 1'b0, n);
      wait_lvl(k, 1'b1, n);
    end
    wait_lvl(k, 1'b0, p);
    wait_lvl(k, 1'b1, n);
    p = p + n;
  endtask : period

  task automatic wr_delay(input int s, input logic adv, input logic ret, output int d);
    int w;
    @(posedge clk_i);
    pc <= '{sel: s[2:0], advance: adv, retard: ret};
    repeat (4) @(posedge clk_i);
    u_fdsp_far_model.write_pulse();
    wait_lvl(2, 1'b1, d);
    wait_lvl(2, 1'b0, w);
    check(w, 4 * RC);
    repeat (4 * RC) @(posedge clk_i);
  endtask : wr_delay

  initial begin
    int n, p, e, nm, l, t;
    rst_b_i = 1'b0;
    head_load_request     = 1'b0;
    test_b  = 1'b1;
    mode    = '0;
    pc      = '0;
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    check({wdo, hlt, wck, win}, 4'h0);
    for (int m = 0; m < 2; m++) begin
      t = m ? HL : HS;
      @(posedge clk_i);
      mode <= '{ctrl_b: 1'b0, density_sel: 1'b0, drive_size_sel: m[0]};
      head_load_request  <= 1'b0;
      repeat (4) @(posedge clk_i);
      head_load_request  <= 1'b1;
      wait_lvl(3, 1'b0, n);
      wait_lvl(3, 1'b1, n);
      check(n >= (t - 2) * RC && n <= (t + 2) * RC, 1'b1);
    end
    // Retrigger: drop and raise mid-count, old expiry must pass unseen
    @(posedge clk_i);
    head_load_request <= 1'b0;
    repeat (4) @(posedge clk_i);
    check(hlt, 1'b0);
    head_load_request <= 1'b1;
    repeat (HL * RC / 2) @(posedge clk_i);
    head_load_request <= 1'b0;
    repeat (4) @(posedge clk_i);
    head_load_request <= 1'b1;
    repeat (HL * RC * 3 / 4) @(posedge clk_i);
    check(hlt, 1'b0);
    wait_lvl(3, 1'b1, n);
    check(n > 0 && n < HL * RC / 2, 1'b1);
    // Head settled, so writes may start
    check(hlt, 1'b1);
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 8; s++) begin
        @(posedge clk_i);
        mode <= '{ctrl_b: 1'b0, density_sel: 1'b0, drive_size_sel: m[0]};
        wr_delay(s, 1'b1, 1'b0, e);
        wr_delay(s, 1'b0, 1'b0, nm);
        wr_delay(s, 1'b0, 1'b1, l);
        check(nm - e, PC_TAB[s] * (m + 1) * RC);
        check(l - nm, PC_TAB[s] * (m + 1) * RC);
      end
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      mode <= fdsp_mode_t'(i[2:0]);
      period(4, p);
      check(p, WCK_TAB[i] * RC);
      if (i >= 4) begin
        period(3, p);
        check(p, (i[0] ? 4 : 2) * RC);
      end
      fork
        repeat (5) begin
          check(sep, !mode.ctrl_b);
          u_fdsp_far_model.read_pulse();
          // Pulse is registered at the edge the task returns on
          @(negedge clk_i);
          check(sep, mode.ctrl_b);
          repeat (DIV_TAB[i] * RC * 7 + 11) @(posedge clk_i);
        end
        begin
          // Skip the half in progress so every measured half is whole
          wait_lvl(0, 1'b0, n);
          repeat (6) begin
            wait_lvl(0, 1'b1, n);
            wait_lvl(0, 1'b0, n);
            check(n >= 6 * DIV_TAB[i] * RC && n <= 11 * DIV_TAB[i] * RC, 1'b1);
          end
        end
      join
    end
    @(posedge clk_i);
    test_b <= 1'b0;
    mode   <= '0;
    head_load_request    <= 1'b0;
    repeat (64 * RC) @(posedge clk_i);
    check(win, 1'b0);
    // Test mode cuts the head-load count to a few reference edges
    head_load_request    <= 1'b1;
    wait_lvl(3, 1'b1, n);
    check(n <= 2 * RC, 1'b1);
    @(posedge clk_i);
    test_b <= 1'b1;
    test_done();
  end

  // Whole sequence needs roughly 45k clocks
  initial begin
    repeat (95000) @(posedge clk_i);
    fail_count++;
    test_done();
  end
endmodule : testbench
